// ===== pkg/ufsirc_params.svh
// What this block does
// - Port one shadow readable only at index 15H
// - Port one shadow copies last run-time write except bits 5:4, which read 0, and bits 2:1, which clear one cycle later
// - Bit 0 enables transmit and receive FIFOs
// - Bit 1 clears receive FIFO, self-clears
// - Bit 2 clears transmit FIFO, self-clears
// - Bit 3 written steers nothing, only reads back in the shadow
// - Bits 7:6 pick trigger 1/4/8/14 bytes
// - Port two shadow alike at index 16H
// - Selection register reachable at index 18h
// - Bits 7:4 route interrupt to line 1-15
// - Bits 3:0 pick DMA 1-3 or none
// - Unselected interrupt lines stay high-impedance
// - Interrupt needs active, enabled event, base above 100h
// - Selection register resets to 00H
// - Location 14H reserved, reads 00H
// - Location 17H reserved, reads 00H
//
// Purpose: Constants of the serial FIFO shadow and infrared routing bank
// Assumes: Configuration index and data strobes come from the config port
// Notes: Offsets are configuration index values
`ifndef UFSIRC_PARAMS_SVH
`define UFSIRC_PARAMS_SVH

// ==========================================================
// Configuration indexes
`define UFS_IDX_RSVD_A 8'h14
`define UFS_IDX_SH1 8'h15
`define UFS_IDX_SH2 8'h16
`define UFS_IDX_RSVD_B 8'h17
`define UFS_IDX_IRDMA 8'h18

// ==========================================================
// Reset and fixed values
`define UFS_BYTE_ZERO 8'h00
`define UFS_RSVD_VAL 8'h00
`define UFS_IRDMA_RST 8'h00
`define UFS_SHADOW_RST 8'h00

// ==========================================================
// FIFO control field layout
`define UFS_FCR_EN 0
`define UFS_FCR_RXCLR 1
`define UFS_FCR_TXCLR 2
`define UFS_FCR_DMAMODE 3
`define UFS_FCR_TRIG_HI 7
`define UFS_FCR_TRIG_LO 6
`define UFS_FCR_KEEP 8'hcf
`define UFS_TRIG_00 4'h1
`define UFS_TRIG_01 4'h4
`define UFS_TRIG_10 4'h8
`define UFS_TRIG_11 4'he

// ==========================================================
// Infrared selection field layout
`define UFS_IRQ_HI 7
`define UFS_IRQ_LO 4
`define UFS_DMA_HI 3
`define UFS_DMA_LO 0
`define UFS_DMA_NONE 4'hf
`define UFS_IRQ_NONE 4'h0
`define UFS_IR_BASE_MIN 16'h0100

`endif

// ===== pkg/ufsirc_pkg.sv
// Purpose: State types of the shadow and routing bank
// Assumes: Constants come from ufsirc_params.svh
// Notes: One packed struct per module
package ufsirc_pkg;

    // ==========================================================
    // Per-port FIFO control shadow state
    typedef struct packed {
        logic [7:0] shadow;
        logic fifo_en;
        logic rx_clr;
        logic tx_clr;
        logic [3:0] trig;
    } ufsirc_shadow_s;

    // ==========================================================
    // Bank state
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] rdata;
        logic claim;
        logic [7:0] ir_sel;
        logic [15:1] irq_out;
        logic [15:1] irq_oe;
        logic [3:1] dma_out;
        logic [3:1] dma_oe;
    } ufsirc_top_s;

endpackage

// ===== core/ufsirc_fifo_shadow.sv
// Purpose: One serial port FIFO control shadow and its FIFO controls
// Assumes: fcr_wr is a one-cycle pulse on core_clk
// Notes: Clear outputs are one-cycle pulses
`timescale 1ns/1ns
`include "ufsirc_params.svh"

module ufsirc_fifo_shadow (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic fcr_wr,
    input wire logic [7:0] fcr_wdata,
    output logic [7:0] shadow,
    output logic fifo_en,
    output logic rx_fifo_clr,
    output logic tx_fifo_clr,
    output logic [3:0] rx_trig_bytes
);

    ufsirc_pkg::ufsirc_shadow_s st;
    ufsirc_pkg::ufsirc_shadow_s next_st;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        // Clear bits fall back one cycle after being set
        next_st.shadow[`UFS_FCR_RXCLR] = 1'b0;
        next_st.shadow[`UFS_FCR_TXCLR] = 1'b0;
        next_st.rx_clr = fcr_wr & fcr_wdata[`UFS_FCR_RXCLR];
        next_st.tx_clr = fcr_wr & fcr_wdata[`UFS_FCR_TXCLR];
        if (fcr_wr)
        begin
            // Bit 3 is kept for readback only and steers nothing
            next_st.shadow = fcr_wdata & `UFS_FCR_KEEP;
            next_st.fifo_en = fcr_wdata[`UFS_FCR_EN];
            case (fcr_wdata[`UFS_FCR_TRIG_HI:`UFS_FCR_TRIG_LO])
                2'h0: next_st.trig = `UFS_TRIG_00;
                2'h1: next_st.trig = `UFS_TRIG_01;
                2'h2: next_st.trig = `UFS_TRIG_10;
                default: next_st.trig = `UFS_TRIG_11;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st.shadow <= `UFS_SHADOW_RST;
            st.fifo_en <= 1'b0;
            st.rx_clr <= 1'b0;
            st.tx_clr <= 1'b0;
            st.trig <= `UFS_TRIG_00;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign shadow = st.shadow;
    assign fifo_en = st.fifo_en;
    assign rx_fifo_clr = st.rx_clr;
    assign tx_fifo_clr = st.tx_clr;
    assign rx_trig_bytes = st.trig;

    // ==========================================================
    // Checks
    property p_rx_clr;
        @(posedge core_clk) disable iff (rst)
        fcr_wr && fcr_wdata[1] |=> rx_fifo_clr && shadow[1]
            ##1 (!shadow[1] || $past(fcr_wr && fcr_wdata[1]));
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx clear not pulsed");

    property p_tx_clr;
        @(posedge core_clk) disable iff (rst)
        fcr_wr && fcr_wdata[2] |=> tx_fifo_clr && shadow[2]
            ##1 (!shadow[2] || $past(fcr_wr && fcr_wdata[2]));
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx clear not pulsed");

    property p_enable;
        @(posedge core_clk) disable iff (rst)
        fcr_wr |=> fifo_en == $past(fcr_wdata[0]) && shadow[5:4] == 2'h0;
    endproperty
    a_enable: assert property (p_enable) else $error("fifo enable wrong");

    property p_trig;
        @(posedge core_clk) disable iff (rst)
        fcr_wr && fcr_wdata[7:6] == 2'h3 |=> rx_trig_bytes == 4'he;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger level wrong");

endmodule

// ===== core/ufsirc_top.sv
// Purpose: Serial FIFO shadows and infrared interrupt and DMA routing
// Assumes: Config strobes are one-cycle pulses on core_clk
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ns
`include "ufsirc_params.svh"

module ufsirc_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfg_mode,
    input wire logic cfg_index_wr,
    input wire logic cfg_data_wr,
    input wire logic cfg_data_rd,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_claim,
    input wire logic u1_fcr_wr,
    input wire logic [7:0] u1_fcr_wdata,
    output logic u1_fifo_en,
    output logic u1_rx_fifo_clr,
    output logic u1_tx_fifo_clr,
    output logic [3:0] u1_rx_trig_bytes,
    input wire logic u2_fcr_wr,
    input wire logic [7:0] u2_fcr_wdata,
    output logic u2_fifo_en,
    output logic u2_rx_fifo_clr,
    output logic u2_tx_fifo_clr,
    output logic [3:0] u2_rx_trig_bytes,
    input wire logic fir_event_active,
    input wire logic fir_event_enable,
    input wire logic [15:0] ir_base_addr,
    input wire logic ir_dma_req,
    output logic [15:1] ir_irq_out,
    output logic [15:1] ir_irq_oe,
    output logic [3:1] ir_dma_out,
    output logic [3:1] ir_dma_oe
);

    ufsirc_pkg::ufsirc_top_s st;
    ufsirc_pkg::ufsirc_top_s next_st;
    logic [7:0] sh1;
    logic [7:0] sh2;
    logic [15:1] irq_line_hit;
    logic [3:1] dma_line_hit;
    logic ir_event;

    // ==========================================================
    // Serial port shadows
    ufsirc_fifo_shadow u_shadow1 (
        .core_clk(core_clk),
        .rst(rst),
        .fcr_wr(u1_fcr_wr),
        .fcr_wdata(u1_fcr_wdata),
        .shadow(sh1),
        .fifo_en(u1_fifo_en),
        .rx_fifo_clr(u1_rx_fifo_clr),
        .tx_fifo_clr(u1_tx_fifo_clr),
        .rx_trig_bytes(u1_rx_trig_bytes)
    );

    ufsirc_fifo_shadow u_shadow2 (
        .core_clk(core_clk),
        .rst(rst),
        .fcr_wr(u2_fcr_wr),
        .fcr_wdata(u2_fcr_wdata),
        .shadow(sh2),
        .fifo_en(u2_fifo_en),
        .rx_fifo_clr(u2_rx_fifo_clr),
        .tx_fifo_clr(u2_tx_fifo_clr),
        .rx_trig_bytes(u2_rx_trig_bytes)
    );

    // ==========================================================
    // Line decode per interrupt and DMA line
    genvar g;
    generate
        for (g = 1; g <= 15; g++)
        begin : g_line
            assign irq_line_hit[g] =
                (st.ir_sel[`UFS_IRQ_HI:`UFS_IRQ_LO] == 4'(g));
            if (g <= 3)
            begin : g_dma
                assign dma_line_hit[g] =
                    (st.ir_sel[`UFS_DMA_HI:`UFS_DMA_LO] == 4'(g));
            end
        end
    endgenerate

    // Event only counts with the controller mapped above the legacy range
    assign ir_event = fir_event_active & fir_event_enable
        & (ir_base_addr > `UFS_IR_BASE_MIN);

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.rdata = `UFS_BYTE_ZERO;
        next_st.claim = 1'b0;
        // Index and data are honoured only in configuration state
        if (cfg_mode && cfg_index_wr)
        begin
            next_st.index = cfg_wdata;
        end
        if (cfg_mode && cfg_data_wr && st.index == `UFS_IDX_IRDMA)
        begin
            next_st.ir_sel = cfg_wdata;
        end
        if (cfg_mode && cfg_data_rd)
        begin
            case (st.index)
                `UFS_IDX_RSVD_A:
                begin
                    next_st.rdata = `UFS_RSVD_VAL;
                    next_st.claim = 1'b1;
                end
                `UFS_IDX_SH1:
                begin
                    next_st.rdata = sh1;
                    next_st.claim = 1'b1;
                end
                `UFS_IDX_SH2:
                begin
                    next_st.rdata = sh2;
                    next_st.claim = 1'b1;
                end
                `UFS_IDX_RSVD_B:
                begin
                    next_st.rdata = `UFS_RSVD_VAL;
                    next_st.claim = 1'b1;
                end
                `UFS_IDX_IRDMA:
                begin
                    next_st.rdata = st.ir_sel;
                    next_st.claim = 1'b1;
                end
                default:
                begin
                    next_st.rdata = `UFS_BYTE_ZERO;
                    next_st.claim = 1'b0;
                end
            endcase
        end
        // Only the selected line is driven; no code drives two lines
        next_st.irq_oe = irq_line_hit;
        next_st.irq_out = irq_line_hit & {15{ir_event}};
        // Reserved and none codes match no channel
        next_st.dma_oe = dma_line_hit;
        next_st.dma_out = dma_line_hit & {3{ir_dma_req}};
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st.index <= `UFS_BYTE_ZERO;
            st.rdata <= `UFS_BYTE_ZERO;
            st.claim <= 1'b0;
            st.ir_sel <= `UFS_IRDMA_RST;
            st.irq_out <= '0;
            st.irq_oe <= '0;
            st.dma_out <= '0;
            st.dma_oe <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cfg_rdata = st.rdata;
    assign cfg_claim = st.claim;
    assign ir_irq_out = st.irq_out;
    assign ir_irq_oe = st.irq_oe;
    assign ir_dma_out = st.dma_out;
    assign ir_dma_oe = st.dma_oe;

    // ==========================================================
    // Checks
    property p_idx_gate;
        @(posedge core_clk) disable iff (rst)
        cfg_index_wr && !cfg_mode |=> st.index == $past(st.index);
    endproperty
    a_idx_gate: assert property (p_idx_gate) else $error("index moved");

    property p_rd_outside;
        @(posedge core_clk) disable iff (rst)
        cfg_data_rd && !cfg_mode |=> cfg_rdata == 8'h00 && !cfg_claim;
    endproperty
    a_rd_outside: assert property (p_rd_outside) else $error("read outside cfg");

    property p_rd_sh1;
        @(posedge core_clk) disable iff (rst)
        cfg_mode && cfg_data_rd && st.index == 8'h15
        |=> cfg_rdata == $past(sh1) && cfg_rdata[5:4] == 2'h0;
    endproperty
    a_rd_sh1: assert property (p_rd_sh1) else $error("shadow one wrong");

    property p_sh2_copy;
        @(posedge core_clk) disable iff (rst)
        u2_fcr_wr ##1 (cfg_mode && cfg_data_rd && st.index == 8'h16 && !u2_fcr_wr)
        |=> (cfg_rdata & 8'hc9) == ($past(u2_fcr_wdata, 2) & 8'hc9);
    endproperty
    a_sh2_copy: assert property (p_sh2_copy) else $error("shadow two wrong");

    property p_rsvd;
        @(posedge core_clk) disable iff (rst)
        cfg_mode && cfg_data_rd && (st.index == 8'h14 || st.index == 8'h17)
        |=> cfg_rdata == 8'h00 && cfg_claim;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved not zero");

    property p_sel_wr;
        @(posedge core_clk) disable iff (rst)
        cfg_data_wr && (cfg_mode && st.index == 8'h18)
        |=> st.ir_sel == $past(cfg_wdata);
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("selection not written");

    property p_irq_none;
        @(posedge core_clk) disable iff (rst)
        st.ir_sel[7:4] == 4'h0 |=> ir_irq_oe == 15'h0000 && ir_irq_out == 15'h0000;
    endproperty
    a_irq_none: assert property (p_irq_none) else $error("line driven");

    property p_irq_cause;
        @(posedge core_clk) disable iff (rst)
        ir_irq_out != 15'h0000
        |-> $past(fir_event_active && fir_event_enable && ir_base_addr > 16'h0100)
            && $onehot(ir_irq_oe) && ((ir_irq_out & ~ir_irq_oe) == 15'h0000);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt");

    property p_dma_none;
        @(posedge core_clk) disable iff (rst)
        st.ir_sel[3:0] == 4'hf || st.ir_sel[3:0] == 4'h0 |=> ir_dma_oe == 3'h0;
    endproperty
    a_dma_none: assert property (p_dma_none) else $error("dma driven");

    property p_reset;
        @(posedge core_clk) rst |=> st.ir_sel == 8'h00 && ir_irq_oe == 15'h0000;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong");

    property p_route;
        @(posedge core_clk) disable iff (rst)
        st.ir_sel[7:4] == 4'h5 |=> ir_irq_oe == 15'h0010;
    endproperty
    a_route: assert property (p_route) else $error("wrong line");

    c_sh1_read: cover property (@(posedge core_clk) disable iff (rst)
        cfg_mode && cfg_data_rd && st.index == 8'h15 ##1 cfg_rdata != 8'h00);
    c_irq_fire: cover property (@(posedge core_clk) disable iff (rst)
        ir_irq_out != 15'h0000);
    c_dma_fire: cover property (@(posedge core_clk) disable iff (rst)
        ir_dma_out != 3'h0);

endmodule

// ===== tb/ufsirc_top_tb.sv
// Purpose: Self-checking bench of the FIFO shadow and infrared routing bank
// Assumes: Inputs change at rising edges by non-blocking assignment
// Notes: Expectations come from the field layout, never from the design
`timescale 1ns/1ns
`include "ufsirc_params.svh"

module ufsirc_top_tb;
    // ==========================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_mode = 1'b1;
    logic cfg_index_wr = 1'b0;
    logic cfg_data_wr = 1'b0;
    logic cfg_data_rd = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic cfg_claim;
    logic u1_fcr_wr = 1'b0;
    logic [7:0] u1_fcr_wdata = 8'h00;
    logic u1_fifo_en, u1_rx_fifo_clr, u1_tx_fifo_clr;
    logic [3:0] u1_rx_trig_bytes;
    logic u2_fcr_wr = 1'b0;
    logic [7:0] u2_fcr_wdata = 8'h00;
    logic u2_fifo_en, u2_rx_fifo_clr, u2_tx_fifo_clr;
    logic [3:0] u2_rx_trig_bytes;
    logic fir_event_active = 1'b0;
    logic fir_event_enable = 1'b0;
    logic [15:0] ir_base_addr = 16'h0000;
    logic ir_dma_req = 1'b0;
    logic [15:1] ir_irq_out, ir_irq_oe;
    logic [3:1] ir_dma_out, ir_dma_oe;
    int n_fail = 0;
    int num_checks = 0;

    always #50 core_clk = ~core_clk;

    ufsirc_top dut (
        .core_clk(core_clk), .rst(rst), .cfg_mode(cfg_mode),
        .cfg_index_wr(cfg_index_wr), .cfg_data_wr(cfg_data_wr),
        .cfg_data_rd(cfg_data_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_claim(cfg_claim), .u1_fcr_wr(u1_fcr_wr), .u1_fcr_wdata(u1_fcr_wdata),
        .u1_fifo_en(u1_fifo_en), .u1_rx_fifo_clr(u1_rx_fifo_clr),
        .u1_tx_fifo_clr(u1_tx_fifo_clr), .u1_rx_trig_bytes(u1_rx_trig_bytes),
        .u2_fcr_wr(u2_fcr_wr), .u2_fcr_wdata(u2_fcr_wdata), .u2_fifo_en(u2_fifo_en),
        .u2_rx_fifo_clr(u2_rx_fifo_clr), .u2_tx_fifo_clr(u2_tx_fifo_clr),
        .u2_rx_trig_bytes(u2_rx_trig_bytes), .fir_event_active(fir_event_active),
        .fir_event_enable(fir_event_enable), .ir_base_addr(ir_base_addr),
        .ir_dma_req(ir_dma_req), .ir_irq_out(ir_irq_out), .ir_irq_oe(ir_irq_oe),
        .ir_dma_out(ir_dma_out), .ir_dma_oe(ir_dma_oe)
    );

    // ==========================================================
    // Compare, bus and closing tasks
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
        @(posedge core_clk);
        cfg_index_wr <= 1'b1;
        cfg_wdata <= idx;
        @(posedge core_clk);
        cfg_index_wr <= 1'b0;
        cfg_data_wr <= 1'b1;
        cfg_wdata <= v;
        @(posedge core_clk);
        cfg_data_wr <= 1'b0;
    endtask

    // Read at idx, compare data and claim
    task automatic cfg_chk(input logic [7:0] idx, input logic [7:0] exp, input logic cl);
        @(posedge core_clk);
        cfg_index_wr <= 1'b1;
        cfg_wdata <= idx;
        @(posedge core_clk);
        cfg_index_wr <= 1'b0;
        cfg_data_rd <= 1'b1;
        @(posedge core_clk);
        cfg_data_rd <= 1'b0;
        #1;
        chk16({8'h00, cfg_rdata}, {8'h00, exp});
        chk1(cfg_claim, cl);
    endtask

    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic reset_case();
        cfg_chk(`UFS_IDX_IRDMA, `UFS_IRDMA_RST, 1'b1);
        cfg_chk(`UFS_IDX_RSVD_A, `UFS_RSVD_VAL, 1'b1);
        cfg_chk(`UFS_IDX_RSVD_B, `UFS_RSVD_VAL, 1'b1);
        chk16({12'h000, u1_rx_trig_bytes}, 16'h0001);
        chk16({1'b0, ir_irq_oe}, 16'h0000);
        cfg_wr(`UFS_IDX_RSVD_A, 8'hff);
        cfg_wr(`UFS_IDX_RSVD_B, 8'hff);
        cfg_wr(`UFS_IDX_SH1, 8'hff);
        cfg_chk(`UFS_IDX_RSVD_A, 8'h00, 1'b1);
        cfg_chk(`UFS_IDX_RSVD_B, 8'h00, 1'b1);
        cfg_chk(`UFS_IDX_SH1, `UFS_SHADOW_RST, 1'b1);
    endtask

    // Run-time FIFO control write on port one (p=0) or two (p=1)
    task automatic fifo_case(input logic p, input logic [7:0] v);
        logic [3:0] t;
        t = v[7:6] == 2'b00 ? 4'h1 : v[7:6] == 2'b01 ? 4'h4 : v[7:6] == 2'b10 ? 4'h8 : 4'he;
        @(posedge core_clk);
        u1_fcr_wr <= ~p;
        u2_fcr_wr <= p;
        u1_fcr_wdata <= v;
        u2_fcr_wdata <= v;
        @(posedge core_clk);
        u1_fcr_wr <= 1'b0;
        u2_fcr_wr <= 1'b0;
        #1;
        chk1(p ? u2_fifo_en : u1_fifo_en, v[0]);
        chk1(p ? u2_rx_fifo_clr : u1_rx_fifo_clr, v[1]);
        chk1(p ? u2_tx_fifo_clr : u1_tx_fifo_clr, v[2]);
        chk16({12'h000, p ? u2_rx_trig_bytes : u1_rx_trig_bytes}, {12'h000, t});
        @(posedge core_clk);
        #1;
        chk1(p ? u2_rx_fifo_clr : u1_rx_fifo_clr, 1'b0);
        chk1(p ? u2_tx_fifo_clr : u1_tx_fifo_clr, 1'b0);
        cfg_chk(p ? `UFS_IDX_SH2 : `UFS_IDX_SH1, v & 8'hc9, 1'b1);
    endtask

    task automatic mode_case();
        @(posedge core_clk);
        cfg_mode <= 1'b0;
        cfg_wr(`UFS_IDX_IRDMA, 8'hff);
        cfg_chk(`UFS_IDX_IRDMA, 8'h00, 1'b0);
        @(posedge core_clk);
        cfg_mode <= 1'b1;
        cfg_chk(`UFS_IDX_IRDMA, 8'h00, 1'b1);
        cfg_chk(8'h19, 8'h00, 1'b0);
    endtask

    task automatic route_case();
        @(posedge core_clk);
        fir_event_active <= 1'b1;
        fir_event_enable <= 1'b1;
        ir_base_addr <= 16'h0101;
        ir_dma_req <= 1'b1;
        cfg_wr(`UFS_IDX_IRDMA, 8'h53);
        cfg_chk(`UFS_IDX_IRDMA, 8'h53, 1'b1);
        settle();
        chk16({1'b0, ir_irq_out}, 16'h0010);
        chk16({1'b0, ir_irq_oe}, 16'h0010);
        chk16({13'h0, ir_dma_oe}, 16'h0004);
        chk16({13'h0, ir_dma_out}, 16'h0004);
        @(posedge core_clk);
        ir_base_addr <= 16'h0100;
        settle();
        chk16({1'b0, ir_irq_out}, 16'h0000);
        @(posedge core_clk);
        ir_base_addr <= 16'h0101;
        fir_event_enable <= 1'b0;
        settle();
        chk16({1'b0, ir_irq_out}, 16'h0000);
        @(posedge core_clk);
        fir_event_enable <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            cfg_wr(`UFS_IDX_IRDMA, {i[3:0], `UFS_DMA_NONE});
            settle();
            chk16({1'b0, ir_irq_oe}, (16'h0001 << i) >> 1);
            chk16({1'b0, ir_irq_out}, (16'h0001 << i) >> 1);
            chk16({13'h0, ir_dma_oe}, 16'h0000);
        end
        for (int i = 0; i < 16; i++)
        begin
            cfg_wr(`UFS_IDX_IRDMA, {`UFS_IRQ_NONE, i[3:0]});
            settle();
            chk16({13'h0, ir_dma_oe}, i > 0 && i < 4 ? (16'h0001 << i) >> 1 : 16'h0);
            chk16({1'b0, ir_irq_oe}, 16'h0000);
        end
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        reset_case();
        fifo_case(1'b0, 8'hc7);
        fifo_case(1'b0, 8'h48);
        fifo_case(1'b1, 8'h86);
        fifo_case(1'b1, 8'h3f);
        mode_case();
        route_case();
        test_done();
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
endmodule
